// ===== include/tcc_pkg.sv
// Purpose: Shared constants and helpers for thermocouple conversion control
// Assumes: Registers are bytes reached over the 4-wire serial port
// Notes:   Sensitivity figures are in units of 0.01 uV per degree C
package tcc_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [6:0] ADDR_CFG_A   = 7'h00;
    localparam logic [6:0] ADDR_CFG_B   = 7'h01;
    localparam logic [6:0] ADDR_CJ_OFF  = 7'h09;
    localparam logic [6:0] ADDR_CJ_HI   = 7'h0A;
    localparam logic [6:0] ADDR_CJ_LO   = 7'h0B;
    localparam logic [7:0] CFG_A_RST    = 8'h00;
    localparam logic [7:0] CFG_B_RST    = 8'h03;
    localparam logic [7:0] CJ_OFF_RST   = 8'h00;
    localparam logic [15:0] CJ_RST      = 16'h0000;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int A_NOTCH50  = 0;
    localparam int A_CJ_DIS   = 3;
    localparam int A_ONESHOT  = 6;
    localparam int A_CONT     = 7;
    localparam int B_AVG_LO   = 4;
    localparam int B_RAW      = 3;
    localparam int B_GAIN32   = 2;
    localparam int OFF_SHIFT  = 2;
    localparam int SENS_SHIFT = 12;
    localparam int INV_SHIFT  = 15;

    // ------------------------------------------------------------------
    // Cold-junction limits: +127.984375 and -64 degrees C
    // ------------------------------------------------------------------
    localparam logic signed [16:0] CJ_MAX = 17'sh07FFC;
    localparam logic signed [16:0] CJ_MIN = 17'sh1C000;

    // ------------------------------------------------------------------
    // Per-type sensitivity, order B E J K N R S T
    // ------------------------------------------------------------------
    localparam logic [15:0] SENS_B = 16'h03F1;
    localparam logic [15:0] SENS_E = 16'h1DD5;
    localparam logic [15:0] SENS_J = 16'h16A3;
    localparam logic [15:0] SENS_K = 16'h1020;
    localparam logic [15:0] SENS_N = 16'h0E2A;
    localparam logic [15:0] SENS_R = 16'h041B;
    localparam logic [15:0] SENS_S = 16'h03BF;
    localparam logic [15:0] SENS_T = 16'h1462;
    localparam logic [31:0] INV_NUM = 32'h0040_0000;

    typedef enum logic [4:0] {
        ST_IDLE   = 5'b00001,
        ST_SAMPLE = 5'b00010,
        ST_LOOKUP = 5'b00100,
        ST_SUM    = 5'b01000,
        ST_STORE  = 5'b10000
    } tcc_state_e;

    // Byte seen by the host at a register address
    function automatic logic [7:0] tcc_read_byte(
        input logic [39:0] image, input logic [6:0] addr);
        unique case (addr)
            ADDR_CFG_A:  tcc_read_byte = image[39:32];
            ADDR_CFG_B:  tcc_read_byte = image[31:24];
            ADDR_CJ_OFF: tcc_read_byte = image[23:16];
            ADDR_CJ_HI:  tcc_read_byte = image[15:8];
            ADDR_CJ_LO:  tcc_read_byte = image[7:0];
            default:     tcc_read_byte = 8'h00;
        endcase
    endfunction

    // Limit a widened cold-junction value and zero its two low bits
    function automatic logic [15:0] tcc_clamp_cj(input logic signed [16:0] v);
        logic signed [16:0] c;
        c = (v > CJ_MAX) ? CJ_MAX : ((v < CJ_MIN) ? CJ_MIN : v);
        tcc_clamp_cj = {c[15:2], 2'b00};
    endfunction

endpackage

// ===== rtl/tcc_lin_table.sv
// Purpose: Linearization table, one word per supported thermocouple type
// Assumes: One read per conversion, address held for a cycle
// Notes:   Word is {inverse sensitivity, sensitivity}; read data registered
`timescale 1ns/10ps
`default_nettype none
module tcc_lin_table (
    // Clock
    input  wire logic        clk,
    // Read port
    input  wire logic [2:0]  addr,
    output var  logic [31:0] rd_data
);
    import tcc_pkg::*;

    // Table lookup with registered output
    always_ff @(posedge clk) begin
        unique case (addr)
            3'h0: rd_data <= {16'(INV_NUM / SENS_B), SENS_B};
            3'h1: rd_data <= {16'(INV_NUM / SENS_E), SENS_E};
            3'h2: rd_data <= {16'(INV_NUM / SENS_J), SENS_J};
            3'h3: rd_data <= {16'(INV_NUM / SENS_K), SENS_K};
            3'h4: rd_data <= {16'(INV_NUM / SENS_N), SENS_N};
            3'h5: rd_data <= {16'(INV_NUM / SENS_R), SENS_R};
            3'h6: rd_data <= {16'(INV_NUM / SENS_S), SENS_S};
            3'h7: rd_data <= {16'(INV_NUM / SENS_T), SENS_T};
        endcase
    end
endmodule // tcc_lin_table
`default_nettype wire

// ===== rtl/tcc_serial_link.sv
// Purpose: Serial port logic on the host-driven serial clock
// Assumes: Mode with data sampled on rising and shifted on falling edge
// Notes:   Chip select high resets the frame; toggles reset only by rst_n
`timescale 1ns/10ps
`default_nettype none
module tcc_serial_link (
    // Pins
    input  wire logic        sck,
    input  wire logic        cs_n,
    input  wire logic        sdi,
    output logic             sdo,
    output logic             sdo_oe,
    // Chip reset
    input  wire logic        rst_n,
    // Frozen register image
    input  wire logic [39:0] image,
    // Events towards the system clock
    output var  logic        wr_tgl,
    output var  logic [6:0]  wr_addr,
    output var  logic [7:0]  wr_data,
    output var  logic        rd_tgl,
    output var  logic [6:0]  rd_addr
);
    import tcc_pkg::*;

    logic [2:0] bit_cnt;
    logic [6:0] shift;
    logic       first;
    logic       is_wr;
    logic [6:0] ptr;
    logic [7:0] tx;
    logic [7:0] rx_byte;
    logic       byte_end;

    assign rx_byte  = {shift, sdi};
    assign byte_end = (bit_cnt == 3'h7);

    // Frame state, cleared by chip select high
    always_ff @(posedge sck or posedge cs_n) begin
        if (cs_n) begin
            bit_cnt <= 3'h0;
            shift   <= 7'h00;
            first   <= 1'b1;
            is_wr   <= 1'b0;
            ptr     <= 7'h00;
        end else begin
            bit_cnt <= bit_cnt + 3'h1;
            shift   <= rx_byte[6:0];
            if (byte_end && first) begin
                first <= 1'b0;
                is_wr <= rx_byte[7];
                ptr   <= rx_byte[6:0];
            end else if (byte_end) begin
                ptr <= ptr + 7'h01;
            end
        end
    end

    // Byte events cross as toggles; a read counts once its first bit shifts
    always_ff @(posedge sck or negedge rst_n) begin
        if (!rst_n) begin
            wr_tgl  <= 1'b0;
            wr_addr <= 7'h00;
            wr_data <= 8'h00;
            rd_tgl  <= 1'b0;
            rd_addr <= 7'h00;
        end else if (!cs_n && !first) begin
            if (byte_end && is_wr) begin
                wr_tgl  <= ~wr_tgl;
                wr_addr <= ptr;
                wr_data <= rx_byte;
            end else if (bit_cnt == 3'h0 && !is_wr) begin
                rd_tgl  <= ~rd_tgl;
                rd_addr <= ptr;
            end
        end
    end

    // Read data shifts out on the falling edge, image is frozen
    always_ff @(negedge sck or posedge cs_n) begin
        if (cs_n) begin
            tx <= 8'h00;
        end else if (bit_cnt == 3'h0 && !first) begin
            tx <= tcc_read_byte(image, ptr);
        end else begin
            tx <= {tx[6:0], 1'b0};
        end
    end

    assign sdo    = tx[7];
    assign sdo_oe = !cs_n && !first && !is_wr;

    a_addr_latch: assert property (@(posedge sck) disable iff (cs_n)
        (first && byte_end) |=> (!first && ptr == $past(rx_byte[6:0])))
        else $error("address byte not latched");
endmodule // tcc_serial_link
`default_nettype wire

// ===== rtl/tcc_conversion_ctrl.sv
// Purpose: Conversion control and cold-junction registers
// Assumes: Analog side answers conv_start with adc_done pulses on clk
// Notes:   Register image is refreshed only while chip select is high
`timescale 1ns/10ps
`default_nettype none

module tcc_conversion_ctrl (
    // System
    input  wire logic        clk,
    input  wire logic        rst_n,
    // Serial pins
    input  wire logic        sck,
    input  wire logic        cs_n,
    input  wire logic        sdi,
    output logic             sdo,
    output logic             sdo_oe,
    // Data ready pin
    output var  logic        result_ready_n,
    // Analog front end
    output var  logic        conv_start,
    input  wire logic        adc_done,
    input  wire logic [18:0] tc_code,
    input  wire logic [15:0] cj_meas,
    output logic             notch_50hz,
    output logic             gain_32,
    output logic             raw_mode,
    output logic             cj_sensor_on,
    // Results
    output var  logic [18:0] tc_temp
);
    import tcc_pkg::*;

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    logic [1:0]  rst_sync;
    logic        rst_i_n;
    logic [2:0]  wr_s;
    logic [2:0]  rd_s;
    logic [2:0]  cs_s;
    logic        wr_fire;
    logic        rd_fire;
    logic        link_idle;
    logic        l_wr_tgl;
    logic        l_rd_tgl;
    logic [6:0]  l_wr_addr;
    logic [7:0]  l_wr_data;
    logic [6:0]  l_rd_addr;
    logic [7:0]  cfg_a;
    logic [7:0]  cfg_b;
    logic [7:0]  cj_off;
    logic [15:0] cj_reg;
    logic [39:0] image;
    tcc_state_e  state;
    logic [3:0]  samp_cnt;
    logic [3:0]  samp_last;
    logic [2:0]  avg_sh;
    logic signed [22:0] tc_acc;
    logic signed [19:0] cj_acc;
    logic signed [18:0] tc_avg;
    logic [15:0] cj_fresh;
    logic [15:0] cj_use;
    logic [31:0] lin_word;
    logic signed [19:0] comp;
    logic signed [16:0] cj_sum;
    logic        start_req;
    logic        cj_read;

    // ------------------------------------------------------------------
    // Reset release and crossings
    // ------------------------------------------------------------------

    // Reset leaves through two flops
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_sync <= 2'b00;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_i_n = rst_sync[1];

    // Three-flop synchronisers for toggles and chip select
    always_ff @(posedge clk or negedge rst_i_n) begin
        if (!rst_i_n) begin
            wr_s <= 3'b000;
            rd_s <= 3'b000;
            cs_s <= 3'b111;
        end else begin
            wr_s <= {wr_s[1:0], l_wr_tgl};
            rd_s <= {rd_s[1:0], l_rd_tgl};
            cs_s <= {cs_s[1:0], cs_n};
        end
    end
    assign wr_fire   = wr_s[1] ^ wr_s[2];
    assign rd_fire   = rd_s[1] ^ rd_s[2];
    assign link_idle = cs_s[1] & cs_s[2];

    tcc_serial_link u_link (
        .sck     (sck),
        .cs_n    (cs_n),
        .sdi     (sdi),
        .sdo     (sdo),
        .sdo_oe  (sdo_oe),
        .rst_n   (rst_i_n),
        .image   (image),
        .wr_tgl  (l_wr_tgl),
        .wr_addr (l_wr_addr),
        .wr_data (l_wr_data),
        .rd_tgl  (l_rd_tgl),
        .rd_addr (l_rd_addr)
    );

    // Image frozen during a frame so multibyte reads agree
    always_ff @(posedge clk or negedge rst_i_n) begin
        if (!rst_i_n) begin
            image <= {CFG_A_RST, CFG_B_RST, CJ_OFF_RST, CJ_RST};
        end else if (link_idle) begin
            image <= {cfg_a, cfg_b, cj_off, cj_reg};
        end
    end

    // ------------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------------

    // Config A; one-shot clear loses to a host write in the same cycle
    always_ff @(posedge clk or negedge rst_i_n) begin
        if (!rst_i_n) begin
            cfg_a <= CFG_A_RST;
        end else if (wr_fire && l_wr_addr == ADDR_CFG_A) begin
            cfg_a <= l_wr_data;
        end else if (state == ST_STORE) begin
            cfg_a[A_ONESHOT] <= 1'b0;
        end
    end

    // Config B and offset
    always_ff @(posedge clk or negedge rst_i_n) begin
        if (!rst_i_n) begin
            cfg_b  <= CFG_B_RST;
            cj_off <= CJ_OFF_RST;
        end else if (wr_fire) begin
            if (l_wr_addr == ADDR_CFG_B) begin
                cfg_b <= l_wr_data;
            end
            if (l_wr_addr == ADDR_CJ_OFF) begin
                cj_off <= l_wr_data;
            end
        end
    end

    assign notch_50hz   = cfg_a[A_NOTCH50];
    assign cj_sensor_on = !cfg_a[A_CJ_DIS];
    assign raw_mode     = cfg_b[B_RAW];
    assign gain_32      = cfg_b[B_RAW] & cfg_b[B_GAIN32];

    // Sample count per result from averaging field
    always_comb begin
        unique case (cfg_b[6:B_AVG_LO])
            3'h0:    avg_sh = 3'h0;
            3'h1:    avg_sh = 3'h1;
            3'h2:    avg_sh = 3'h2;
            3'h3:    avg_sh = 3'h3;
            default: avg_sh = 3'h4;
        endcase
    end
    assign samp_last = 4'((5'h01 << avg_sh) - 5'h01);

    // ------------------------------------------------------------------
    // Conversion sequencer
    // ------------------------------------------------------------------
    assign start_req = cfg_a[A_CONT] || cfg_a[A_ONESHOT];

    // State and start pulse
    always_ff @(posedge clk or negedge rst_i_n) begin
        if (!rst_i_n) begin
            state      <= ST_IDLE;
            conv_start <= 1'b0;
        end else begin
            conv_start <= 1'b0;
            unique case (state)
                ST_IDLE: begin
                    if (start_req) begin
                        state      <= ST_SAMPLE;
                        conv_start <= 1'b1;
                    end
                end
                ST_SAMPLE: begin
                    if (adc_done && samp_cnt == samp_last) begin
                        state <= ST_LOOKUP;
                    end else if (adc_done) begin
                        conv_start <= 1'b1;
                    end
                end
                ST_LOOKUP: state <= ST_SUM;
                ST_SUM:    state <= ST_STORE;
                ST_STORE: begin
                    state      <= cfg_a[A_CONT] ? ST_SAMPLE : ST_IDLE;
                    conv_start <= cfg_a[A_CONT];
                end
            endcase
        end
    end

    // Sample accumulation, held through lookup and sum for the result
    always_ff @(posedge clk or negedge rst_i_n) begin
        if (!rst_i_n) begin
            samp_cnt <= 4'h0;
            tc_acc   <= 23'sh0;
            cj_acc   <= 20'sh0;
        end else if (state == ST_IDLE || state == ST_STORE) begin
            samp_cnt <= 4'h0;
            tc_acc   <= 23'sh0;
            cj_acc   <= 20'sh0;
        end else if (state == ST_SAMPLE && adc_done) begin
            samp_cnt <= samp_cnt + 4'h1;
            tc_acc   <= tc_acc + 23'(signed'(tc_code));
            cj_acc   <= cj_acc + 20'(signed'(cj_meas));
        end
    end

    // Averages, measured value plus offset clamped
    assign tc_avg = 19'(tc_acc >>> avg_sh);
    assign cj_sum = 17'(signed'(16'(cj_acc >>> avg_sh)))
                  + 17'(signed'({cj_off, 2'b00}) <<< OFF_SHIFT);
    assign cj_fresh = tcc_clamp_cj(cj_sum);
    assign cj_use   = cj_sensor_on ? cj_fresh : cj_reg;

    tcc_lin_table u_table (
        .clk     (clk),
        .addr    (cfg_b[2:0]),
        .rd_data (lin_word)
    );

    // Compensated code and degrees C
    always_ff @(posedge clk or negedge rst_i_n) begin
        if (!rst_i_n) begin
            comp    <= 20'sh0;
            tc_temp <= 19'h0;
        end else if (state == ST_SUM) begin
            comp <= raw_mode ? 20'(tc_avg) : 20'(tc_avg)
                  + 20'((34'(signed'(cj_use))
                         * 34'(signed'({1'b0, lin_word[15:0]})))
                        >>> SENS_SHIFT);
        end else if (state == ST_STORE) begin
            tc_temp <= raw_mode ? 19'(comp)
                     : 19'((37'(comp)
                            * 37'(signed'({1'b0, lin_word[31:16]})))
                           >>> INV_SHIFT);
        end
    end

    // ------------------------------------------------------------------
    // Cold-junction register
    // ------------------------------------------------------------------

    // Measured copy when sensor on, host bytes when off
    always_ff @(posedge clk or negedge rst_i_n) begin
        if (!rst_i_n) begin
            cj_reg <= CJ_RST;
        end else if (cj_sensor_on) begin
            if (state == ST_STORE) begin
                cj_reg <= cj_fresh;
            end
        end else if (wr_fire && l_wr_addr == ADDR_CJ_HI) begin
            cj_reg[15:8] <= l_wr_data;
        end else if (wr_fire && l_wr_addr == ADDR_CJ_LO) begin
            cj_reg[7:0] <= {l_wr_data[7:2], 2'b00};
        end
    end

    // ------------------------------------------------------------------
    // Data ready pin
    // ------------------------------------------------------------------
    assign cj_read = rd_fire && cj_sensor_on
                  && (l_rd_addr == ADDR_CJ_HI || l_rd_addr == ADDR_CJ_LO);

    // New result wins over a clearing read in the same cycle
    always_ff @(posedge clk or negedge rst_i_n) begin
        if (!rst_i_n) begin
            result_ready_n <= 1'b1;
        end else if (state == ST_STORE) begin
            result_ready_n <= 1'b0;
        end else if (cj_read) begin
            result_ready_n <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_i_n);

    sequence s_store;
        state == ST_STORE;
    endsequence

    sequence s_last_sample;
        state == ST_SAMPLE && adc_done && samp_cnt == samp_last;
    endsequence

    a_notch_write: assert property (
        wr_fire && l_wr_addr == ADDR_CFG_A |=> notch_50hz == $past(l_wr_data[0]))
        else $error("notch select did not follow write");

    a_avg_samples: assert property (
        s_last_sample |=> state == ST_LOOKUP ##2 state == ST_STORE)
        else $error("averaging count wrong");

    a_cont_restart: assert property (
        s_store and cfg_a[A_CONT] |=> conv_start && state == ST_SAMPLE)
        else $error("continuous mode did not restart");

    a_off_stays_idle: assert property (
        state == ST_IDLE && !start_req |=> !conv_start && state == ST_IDLE)
        else $error("conversion started while off");

    a_oneshot_clear: assert property (
        s_store and !wr_fire |=> !cfg_a[A_ONESHOT])
        else $error("one-shot bit not cleared");

    a_raw_passes: assert property (
        state == ST_SUM && raw_mode |=> comp == 20'($past(tc_avg)))
        else $error("raw mode altered code");

    a_cj_range: assert property (
        s_store and cj_sensor_on |=> signed'(cj_reg) <= 16'sh7FFC
            && signed'(cj_reg) >= 16'shC000 && cj_reg[1:0] == 2'b00)
        else $error("cold-junction value out of range");

    a_ready_low: assert property (
        s_store |=> !result_ready_n)
        else $error("ready not asserted after store");

    a_ready_clear: assert property (
        cj_read && state != ST_STORE |=> result_ready_n)
        else $error("ready not cleared by read");

    a_cj_hold: assert property (
        !cj_sensor_on && !wr_fire |=> $stable(cj_reg))
        else $error("cold-junction value changed while sensor off");

endmodule // tcc_conversion_ctrl
`default_nettype wire

// ===== bench/tcc_spi_host.sv
// Purpose: Host model on the 4-wire serial port, making its own clock
// Assumes: Clock idles low; device samples rising, shifts on falling edge
// Notes:   Data line is inverted between frames so stale bits never match
`timescale 1ns/10ps
`default_nettype none
module tcc_spi_host (
    // Serial pins
    output var  logic       sck,
    output var  logic       cs_n,
    output var  logic       sdi,
    input  wire logic       sdo,
    // Received read byte
    output var  logic       got,
    output var  logic [7:0] rx
);
    // ------------------------------------------------------------------
    // Idle levels
    // ------------------------------------------------------------------
    initial begin
        sck = 1'b0;
        cs_n = 1'b1;
        sdi = 1'b0;
        got = 1'b0;
        rx = 8'h00;
    end

    // One frame: command byte, then n data bytes, 32 ns serial clock
    task automatic frame(input logic wr, input logic [6:0] a,
                         input int n, input logic [15:0] d);
        logic [23:0] sh;
        sh = {wr, a, d};
        #7 cs_n = 1'b0;
        for (int i = 0; i < 8 * (n + 1); i++) begin
            sdi = sh[23];
            #16 sck = 1'b1;
            rx = {rx[6:0], sdo};
            sh = sh << 1;
            #16 sck = 1'b0;
            got = !wr && i % 8 == 7 && i > 7;
        end
        #16 cs_n = 1'b1;
        sdi = ~sdi;
        got = 1'b0;
        #150;
    endtask
endmodule // tcc_spi_host
`default_nettype wire

// ===== bench/tb_thermocouple_conversion_control.sv
// Purpose: Self-checking bench for conversion control and CJ registers
// Assumes: Analog side is played by the bench on clk
// Notes:   Read bytes are checked against a queue of expected values
`timescale 1ns/10ps
`default_nettype none
module tb_thermocouple_conversion_control;
    import tcc_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0, adc_done = 1'b0;
    logic sck, cs_n, sdi, sdo, sdo_oe, rdy_n, cstart, got;
    logic notch, g32, raw, cj_on;
    logic [18:0] tc_code = '0, tc_temp;
    logic [15:0] cj_meas = '0, cjx;
    logic [7:0] rx;
    logic [7:0] exq[$];
    int error_cnt = 0, checked = 0, starts = 0, cyc = 0, seed = 84;

    tcc_conversion_ctrl u_tcc_conversion_ctrl (.clk(clk), .rst_n(rst_n),
        .sck(sck), .cs_n(cs_n), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe),
        .result_ready_n(rdy_n), .conv_start(cstart), .adc_done(adc_done),
        .tc_code(tc_code), .cj_meas(cj_meas), .notch_50hz(notch),
        .gain_32(g32), .raw_mode(raw), .cj_sensor_on(cj_on),
        .tc_temp(tc_temp));
    tcc_spi_host u_tcc_spi_host (.sck(sck), .cs_n(cs_n), .sdi(sdi),
        .sdo(sdo), .got(got), .rx(rx));

    // Clock, start counter and hang limit
    initial forever #4 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cstart === 1'b1) starts++;
        if (cyc == 6000) begin
            error_cnt++;
            report_and_stop();
        end
    end

    task automatic chk(input string n, input logic [7:0] e,
                       input logic [7:0] s);
        checked++;
        if (s !== e) begin
            error_cnt++;
            $display("wrong value %s exp %h seen %h", n, e, s);
        end
    endtask

    task automatic chk_temp(input logic [18:0] e, input logic [18:0] s);
        checked++;
        if (s !== e) begin
            error_cnt++;
            $display("wrong value tc_temp exp %h seen %h", e, s);
        end
    endtask

    // Oldest expected byte against each byte read back
    always @(posedge got) begin
        chk("drive", 8'h01, {7'h00, sdo_oe});
        if (exq.size() == 0) error_cnt++;
        else chk("read byte", exq.pop_front(), rx);
    end

    task automatic rd(input logic [6:0] a, input int n, input logic [15:0] e);
        if (n == 2) exq.push_back(e[15:8]);
        exq.push_back(e[7:0]);
        u_tcc_spi_host.frame(1'b0, a, n, 16'h0000);
    endtask

    task automatic wr(input logic [6:0] a, input logic [7:0] b);
        u_tcc_spi_host.frame(1'b1, a, 1, {b, 8'h00});
    endtask

    // Answer n sample requests with the given cold-junction value
    task automatic conv(input int n, input logic [15:0] cj);
        for (int i = 0; i < n; i++) begin
            for (int k = 0; k < 200 && starts == 0; k++) @(negedge clk);
            starts--;
            @(posedge clk);
            adc_done <= 1'b1;
            cj_meas <= cj;
            tc_code <= 19'($random(seed));
            @(posedge clk);
            adc_done <= 1'b0;
        end
        repeat (10) @(negedge clk);
    endtask

    task automatic report_and_stop();
        $display("checked %0d error_cnt %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        cjx = {3'b000, 11'($random(seed)), 2'b00};
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        repeat (8) @(posedge clk);
        rd(ADDR_CFG_A, 1, {8'h00, CFG_A_RST});
        rd(ADDR_CFG_B, 1, {8'h00, CFG_B_RST});
        rd(ADDR_CJ_OFF, 1, 16'h0000);
        rd(7'h05, 1, 16'h0000);
        wr(ADDR_CFG_B, 8'h0C);
        chk("raw", 8'h03, {6'h00, raw, g32});
        wr(ADDR_CFG_B, 8'h13);
        chk("raw", 8'h00, {6'h00, raw, g32});
        wr(ADDR_CJ_OFF, 8'h10);
        wr(ADDR_CFG_A, 8'h41);
        chk("notch", 8'h03, {6'h00, notch, cj_on});
        conv(2, cjx);
        chk("ready", 8'h00, {7'h00, rdy_n});
        rd(ADDR_CJ_HI, 2, cjx + 16'h0100);
        chk("ready", 8'h01, {7'h00, rdy_n});
        rd(ADDR_CFG_A, 1, 16'h0001);
        wr(ADDR_CJ_HI, 8'h55);
        rd(ADDR_CJ_HI, 2, cjx + 16'h0100);
        wr(ADDR_CFG_A, 8'h80);
        conv(2, 16'h7FFC);
        wr(ADDR_CFG_A, 8'h08);
        chk("sensor", 8'h00, {7'h00, cj_on});
        rd(ADDR_CJ_HI, 2, CJ_MAX[15:0]);
        u_tcc_spi_host.frame(1'b1, ADDR_CJ_HI, 2, 16'h1235);
        rd(ADDR_CJ_HI, 2, 16'h1234);
        // Raw gain, one sample: ends the conversion left waiting
        wr(ADDR_CFG_B, 8'h0C);
        conv(1, 16'h0000);
        chk_temp(tc_code, tc_temp);
        repeat (20) @(posedge clk);
        chk("queue", 8'h00, 8'(exq.size()));
        chk("drive", 8'h00, {7'h00, sdo_oe});
        report_and_stop();
    end
endmodule // tb_thermocouple_conversion_control
`default_nettype wire
